// ===== inc/twx_pkg.sv
// constants, types and register map of the table-write / test-skip / xor
// execution slice; shared by the core and its data memory
package twx_pkg;

  localparam int DADDR_W = 12;
  localparam int DATA_W  = 8;

  // apb byte offsets, one aligned word each; OFF_HOLD_PAGE is the paddr[7:5] page of the holding words
  localparam logic [7:0] OFF_INSTR      = 8'h00;
  localparam logic [7:0] OFF_NEXT       = 8'h04;
  localparam logic [7:0] OFF_WREG       = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_BANK       = 8'h10;
  localparam logic [7:0] OFF_TPTR       = 8'h14;
  localparam logic [7:0] OFF_TLAT       = 8'h18;
  localparam logic [7:0] OFF_EXEC       = 8'h1C;
  localparam logic [2:0] OFF_HOLD_PAGE  = 3'h1;
  localparam logic [7:0] OFF_DADDR      = 8'h40;
  localparam logic [7:0] OFF_DDATA      = 8'h44;

  // status flag positions
  localparam int ST_N = 4;
  localparam int ST_Z = 2;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [7:0]  RST_HOLD = 8'hFF;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // opcode patterns
  localparam logic [13:0] OPC_TABLE_WRITE = 14'h0003;
  localparam logic [6:0]  OPC_TSTZ  = 7'h33;
  localparam logic [7:0]  OPC_XORL  = 8'h0A;
  localparam logic [5:0]  OPC_XORF  = 6'h06;

  // operand bit positions
  localparam int BIT_DEST = 9;
  localparam int BIT_ACC  = 8;

  // access bank split: low half bank 0, high half top bank
  localparam int         ACC_SPLIT   = 7;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;

  // q phases
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // instruction cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TABLE_WRITE = 2'h2;
  localparam logic [1:0] CYC_SKIP1 = 2'h2;
  localparam logic [1:0] CYC_SKIP2 = 2'h3;

  // table pointer modes
  localparam logic [1:0] TM_NONE = 2'h0;
  localparam logic [1:0] TM_POST = 2'h1;
  localparam logic [1:0] TM_DEC  = 2'h2;
  localparam logic [1:0] TM_PRE  = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } twx_state_t;

  typedef enum logic [2:0] {
    OP_NOP   = 3'b000,
    OP_TABLE_WRITE = 3'b001,
    OP_TSTZ  = 3'b010,
    OP_XORL  = 3'b011,
    OP_XORF  = 3'b100
  } twx_op_t;

  typedef struct packed {
    logic               we;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } twx_mem_req_t;

endpackage

// ===== verilog/twx_dmem.sv
// data memory of the slice: flip-flop array, combinational read
// assumes one requester at a time, muxed by the core
module twx_dmem
  import twx_pkg::*;
#(
  parameter int DEPTH = 4096
)
(
  input  wire logic              pclk,
  input  wire twx_mem_req_t      req,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem_r [DEPTH];

  // no reset: contents are data, not control
  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem_r[req.addr] <= req.wdata;
    end
  end

  assign rdata = mem_r[req.addr];

endmodule

// ===== verilog/twx_exec.sv
// execution slice for table write, test-and-skip and the two xor forms
// assumes an apb master on pclk; one instruction issued per write to OFF_INSTR
module twx_exec
  import twx_pkg::*;
#(
  parameter int HOLD_N = 8,
  parameter int TPTR_W = 21
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             exec_busy
);

  localparam int HIW = $clog2(HOLD_N);

  twx_state_t          state_r;
  twx_op_t             op_r;
  logic [1:0]          q_r, cyc_r, ncyc_r;
  logic [15:0]         instr_r, next_r;
  logic [7:0]          w_r, status_r, tlat_r;
  logic [7:0]          opnd_r, res_r, tl_r;
  logic [3:0]          bank_r;
  logic [TPTR_W-1:0]   tptr_r, eptr;
  logic [7:0]          hold_r [HOLD_N];
  logic [DADDR_W-1:0]  daddr_r, ea;
  logic                skip_r, busy_d_r;
  logic [31:0]         prdata_r, rd_nxt;
  logic                mapped, busy, apb_wr, start;
  logic                last, done, wb, tbl_cyc2, hold_we;
  logic [HIW-1:0]      hidx;
  logic [7:0]          mdata;
  twx_mem_req_t        mreq;

  function automatic twx_op_t decode(input logic [15:0] i);
    twx_op_t o;
    o = OP_NOP;
    if (i[15:2] == OPC_TABLE_WRITE) begin
      o = OP_TABLE_WRITE;
    end else if (i[15:9] == OPC_TSTZ) begin
      o = OP_TSTZ;
    end else if (i[15:8] == OPC_XORL) begin
      o = OP_XORL;
    end else if (i[15:10] == OPC_XORF) begin
      o = OP_XORF;
    end
    return o;
  endfunction

  function automatic logic [DADDR_W-1:0] eff_addr(input logic       a,
                                                 input logic [7:0] f,
                                                 input logic [3:0] b);
    logic [3:0] bk;
    bk = b;
    if (!a) begin
      bk = f[ACC_SPLIT] ? ACC_HI_BANK : ACC_LO_BANK;
    end
    return {bk, f};
  endfunction

  // second-word opcodes: move-file, call/goto, load-pointer
  function automatic logic two_word(input logic [15:0] i);
    return (i[15:12] == 4'hC) || (i[15:10] == 6'h3B) ||
           (i[15:8] == 8'hEF) || (i[15:4] == 12'hEE0);
  endfunction

  assign busy      = state_r != ST_IDLE;
  assign exec_busy = busy;
  // wait one idle cycle so prdata_r is rebuilt from settled state
  assign pready    = psel && penable && !busy && !busy_d_r;
  assign pslverr   = pready && !mapped;
  assign prdata    = prdata_r;
  assign apb_wr    = pready && pwrite;
  assign start     = apb_wr && paddr == OFF_INSTR;
  assign last      = cyc_r == 2'(ncyc_r - CYC_ONE);
  assign done      = busy && q_r == Q4 && last;
  assign wb        = busy && q_r == Q4 && cyc_r == 2'h0;
  assign ea        = eff_addr(instr_r[BIT_ACC], instr_r[7:0], bank_r);
  assign tbl_cyc2  = op_r == OP_TABLE_WRITE && cyc_r == 2'h1;
  assign hold_we   = busy && tbl_cyc2 && q_r == Q4;
  assign eptr      = (instr_r[1:0] == TM_PRE) ? TPTR_W'(tptr_r + 1'b1)
                                              : tptr_r;
  assign hidx      = eptr[HIW-1:0];

  // core owns the port while busy, apb only while idle
  always_comb begin
    mreq = '0;
    if (busy) begin
      mreq.addr  = ea;
      mreq.we    = wb && op_r == OP_XORF && instr_r[BIT_DEST];
      mreq.wdata = res_r;
    end else begin
      mreq.addr  = daddr_r;
      mreq.we    = apb_wr && paddr == OFF_DDATA;
      mreq.wdata = pwdata[7:0];
    end
  end

  twx_dmem u_dmem (
    .pclk  (pclk),
    .req   (mreq),
    .rdata (mdata)
  );

  // phase and cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      q_r     <= Q1;
      cyc_r   <= 2'h0;
      ncyc_r  <= CYC_ONE;
      skip_r  <= 1'b0;
    end else if (start) begin
      state_r <= ST_EXEC;
      q_r     <= Q1;
      cyc_r   <= 2'h0;
      ncyc_r  <= CYC_ONE;
      skip_r  <= 1'b0;
    end else if (busy) begin
      q_r <= 2'(q_r + 2'h1);
      if (q_r == Q1 && cyc_r == 2'h0) begin
        ncyc_r <= (decode(instr_r) == OP_TABLE_WRITE) ? CYC_TABLE_WRITE
                                                      : CYC_ONE;
      end
      if (q_r == Q3 && cyc_r == 2'h0 && op_r == OP_TSTZ &&
          opnd_r == RST_BYTE) begin
        skip_r <= 1'b1;
        ncyc_r <= two_word(next_r) ? CYC_SKIP2 : CYC_SKIP1;
      end
      if (q_r == Q4) begin
        if (last) begin
          state_r <= ST_IDLE;
        end else begin
          cyc_r   <= 2'(cyc_r + 2'h1);
          state_r <= (op_r == OP_TSTZ) ? ST_SKIP : ST_EXEC;
        end
      end
    end
  end

  // decode, operand read and processing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r   <= OP_NOP;
      opnd_r <= RST_BYTE;
      res_r  <= RST_BYTE;
      tl_r   <= RST_BYTE;
    end else if (busy) begin
      case (q_r)
        Q1: begin
          if (cyc_r == 2'h0) begin
            op_r <= decode(instr_r);
          end
        end
        Q2: begin
          if (cyc_r == 2'h0) begin
            opnd_r <= (op_r == OP_XORL) ? instr_r[7:0] : mdata;
          end
          if (tbl_cyc2) begin
            tl_r <= tlat_r;
          end
        end
        Q3: begin
          if (cyc_r == 2'h0) begin
            res_r <= w_r ^ opnd_r;
          end
        end
        default: ;
      endcase
    end
  end

  // accumulator and status; hardware write wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r      <= RST_BYTE;
      status_r <= RST_BYTE;
    end else begin
      if (wb && (op_r == OP_XORL ||
                 (op_r == OP_XORF && !instr_r[BIT_DEST]))) begin
        w_r <= res_r;
      end else if (apb_wr && paddr == OFF_WREG) begin
        w_r <= pwdata[7:0];
      end
      if (wb && (op_r == OP_XORL || op_r == OP_XORF)) begin
        status_r[ST_N] <= res_r[7];
        status_r[ST_Z] <= res_r == RST_BYTE;
      end else if (apb_wr && paddr == OFF_STATUS) begin
        status_r <= pwdata[7:0];
      end
    end
  end

  // table pointer, latch and holding registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tptr_r <= '0;
      tlat_r <= RST_BYTE;
      for (int k = 0; k < HOLD_N; k++) begin
        hold_r[k] <= RST_HOLD;
      end
    end else begin
      if (hold_we) begin
        hold_r[hidx] <= tl_r;
        case (instr_r[1:0])
          TM_POST: tptr_r <= TPTR_W'(tptr_r + 1'b1);
          TM_DEC:  tptr_r <= TPTR_W'(tptr_r - 1'b1);
          TM_PRE:  tptr_r <= eptr;
          default: ;
        endcase
      end else if (apb_wr && paddr == OFF_TPTR) begin
        tptr_r <= pwdata[TPTR_W-1:0];
      end
      if (apb_wr && paddr == OFF_TLAT) begin
        tlat_r <= pwdata[7:0];
      end
    end
  end

  // software-only registers and the one-cycle busy delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r  <= RST_WORD;
      next_r   <= RST_WORD;
      bank_r   <= RST_BANK;
      daddr_r  <= '0;
      busy_d_r <= 1'b0;
    end else begin
      busy_d_r <= busy;
      if (start) begin
        instr_r <= pwdata[15:0];
      end
      if (apb_wr && paddr == OFF_NEXT) begin
        next_r <= pwdata[15:0];
      end
      if (apb_wr && paddr == OFF_BANK) begin
        bank_r <= pwdata[3:0];
      end
      if (apb_wr && paddr == OFF_DADDR) begin
        daddr_r <= pwdata[DADDR_W-1:0];
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    mapped = 1'b1;
    case (paddr)
      OFF_INSTR:  rd_nxt[15:0] = instr_r;
      OFF_NEXT:   rd_nxt[15:0] = next_r;
      OFF_WREG:   rd_nxt[7:0]  = w_r;
      OFF_STATUS: rd_nxt[7:0]  = status_r;
      OFF_BANK:   rd_nxt[3:0]  = bank_r;
      OFF_TPTR:   rd_nxt[TPTR_W-1:0] = tptr_r;
      OFF_TLAT:   rd_nxt[7:0]  = tlat_r;
      OFF_EXEC:   rd_nxt[5:0]  = {ncyc_r, 2'h0, skip_r, busy};
      OFF_DADDR:  rd_nxt[DADDR_W-1:0] = daddr_r;
      OFF_DDATA:  rd_nxt[7:0]  = mdata;
      default: begin
        if (paddr[7:5] == OFF_HOLD_PAGE && paddr[1:0] == 2'h0 &&
            32'(paddr[4:2]) < HOLD_N) begin
          rd_nxt[7:0] = hold_r[paddr[HIW+1:2]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // rebuilt every selected cycle; pready waits one idle cycle for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel) begin
      prdata_r <= rd_nxt;
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_table_write_len;
    start && decode(pwdata[15:0]) == OP_TABLE_WRITE |-> ##8 done;
  endproperty
  a_table_write_len: assert property (p_table_write_len)
    else $error("table write did not end after two cycles");
  property p_hold_write;
    hold_we |=> hold_r[$past(hidx)] == $past(tl_r);
  endproperty
  a_hold_write: assert property (p_hold_write)
    else $error("holding register not loaded from latch");
  property p_post_inc;
    hold_we && instr_r[1:0] == TM_POST |=>
      tptr_r == TPTR_W'($past(tptr_r) + 1'b1);
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("pointer not post-incremented");
  property p_skip_one;
    done && op_r == OP_TSTZ && skip_r && !two_word(next_r)
      |-> ncyc_r == CYC_SKIP1 && cyc_r == 2'h1;
  endproperty
  a_skip_one: assert property (p_skip_one)
    else $error("skip over one-word instruction not two cycles");
  property p_skip_two;
    done && op_r == OP_TSTZ && skip_r && two_word(next_r)
      |-> cyc_r == 2'h2;
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("skip over two-word instruction not three cycles");
  property p_tst_flags;
    busy && op_r == OP_TSTZ && q_r != Q1 |=> $stable(status_r);
  endproperty
  a_tst_flags: assert property (p_tst_flags)
    else $error("test-and-skip changed status");
  property p_xorl_result;
    busy && q_r == Q2 && op_r == OP_XORL ##2 wb |=>
      w_r == ($past(w_r, 3) ^ $past(instr_r[7:0], 3)) &&
      status_r[ST_Z] == (w_r == RST_BYTE) &&
      status_r[ST_N] == w_r[7];
  endproperty
  a_xorl_result: assert property (p_xorl_result)
    else $error("xor literal result or flags wrong");
  // w must take the result only when d is 0
  property p_xorf_dest;
    wb && op_r == OP_XORF |-> mreq.we == instr_r[BIT_DEST] &&
      mreq.addr == ea ##1
      w_r == ($past(instr_r[BIT_DEST]) ? $past(w_r) : $past(res_r));
  endproperty
  a_xorf_dest: assert property (p_xorf_dest)
    else $error("xor register destination wrong");
  property p_access_bank;
    busy && !instr_r[BIT_ACC] |->
      mreq.addr[DADDR_W-1:8] == (instr_r[ACC_SPLIT] ? ACC_HI_BANK
                                                    : ACC_LO_BANK);
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank not forced");
  property p_phase_walk;
    busy && q_r == Q1 |=> q_r == Q2 ##1 q_r == Q3 ##1 q_r == Q4;
  endproperty
  a_phase_walk: assert property (p_phase_walk)
    else $error("phase sequence broken");

  c_table_write_pre: cover property (hold_we && instr_r[1:0] == TM_PRE);
  c_skip_two: cover property (done && skip_r && cyc_r == 2'h2);
  c_xorf_mem: cover property (wb && op_r == OP_XORF && instr_r[BIT_DEST]);
  c_unmapped: cover property (pslverr);

endmodule

// ===== bench/tb_twx_exec.sv
// self-checking bench for the table-write / test-skip / xor slice
// assumes twx_exec answers on apb and the package offsets and flag bits
module tb_twx_exec
  import twx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        exec_busy;
  int          fail_count  = 0;
  int          checks_done = 0;

  twx_exec dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .exec_busy (exec_busy)
  );

  always #20 pclk = ~pclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // holds the request until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t bus wait ran out", $time);
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string msg);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h00000000, r, e);
    chk(r, exp, msg);
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
    wr(OFF_DADDR, {20'h00000, a});
    wr(OFF_DDATA, {24'h000000, v});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
    wr(OFF_DADDR, {20'h00000, a});
    rdchk(OFF_DDATA, {24'h000000, v}, "data memory");
  endtask

  // busy lasts four pclk per instruction cycle
  task automatic run(input logic [15:0] ins, input int cyc,
                     input logic skip);
    int n;
    wr(OFF_INSTR, {16'h0000, ins});
    n = 0;
    while (n < 40) begin
      @(posedge pclk);
      if (exec_busy !== 1'b1) break;
      n++;
    end
    chk(32'(n), 32'(4 * cyc), "busy span");
    rdchk(OFF_EXEC, {26'h0, 2'(cyc), 2'h0, skip, 1'b0}, "exec status");
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdchk(OFF_WREG, 32'h00000000, "w reset");
    rdchk(OFF_STATUS, 32'h00000000, "status reset");
    rdchk(OFF_TPTR, 32'h00000000, "pointer reset");
    for (int i = 0; i < 8; i++)
      rdchk(8'h20 + 8'(4 * i), 32'h000000FF, "holding reset");
    xfer(1'b0, 8'h80, 32'h00000000, r, e);
    chk({31'h0, e}, 32'h00000001, "unmapped error");
    $display("test reset done");
  endtask

  // xor literal: w, k, status before, w after, status after
  task automatic t_xorl();
    logic [7:0] tv [3][5] = '{'{8'hB5, 8'hAF, 8'h00, 8'h1A, 8'h00},
                              '{8'h1A, 8'h1A, 8'h1B, 8'h00, 8'h0F},
                              '{8'h00, 8'h80, 8'h04, 8'h80, 8'h10}};
    for (int i = 0; i < 3; i++) begin
      wr(OFF_WREG, {24'h0, tv[i][0]});
      wr(OFF_STATUS, {24'h0, tv[i][2]});
      run({8'h0A, tv[i][1]}, 1, 1'b0);
      rdchk(OFF_WREG, {24'h0, tv[i][3]}, "xor literal w");
      rdchk(OFF_STATUS, {24'h0, tv[i][4]}, "xor literal flags");
    end
    // undecoded word runs as a single no-op cycle
    run(16'hFFFF, 1, 1'b0);
    rdchk(OFF_WREG, 32'h00000080, "no-op keeps w");
    $display("test xor literal done");
  endtask

  // decoy byte in bank 2 shows a forced access bank
  task automatic xf(input logic [15:0] ins, input logic [11:0] ea,
                    input logic [7:0] w, input logic [7:0] mv,
                    input logic [7:0] ew, input logic [7:0] em,
                    input logic [7:0] est);
    wr(OFF_BANK, 32'h00000002);
    mem_wr({4'h2, ins[7:0]}, 8'h00);
    mem_wr(ea, mv);
    wr(OFF_WREG, {24'h0, w});
    wr(OFF_STATUS, 32'h00000000);
    run(ins, 1, 1'b0);
    rdchk(OFF_WREG, {24'h0, ew}, "xor register w");
    mem_chk(ea, em);
    rdchk(OFF_STATUS, {24'h0, est}, "xor register flags");
  endtask

  task automatic t_xorf();
    xf(16'h1B34, 12'h234, 8'hB5, 8'hAF, 8'hB5, 8'h1A, 8'h00);
    xf(16'h1890, 12'hF90, 8'h35, 8'h35, 8'h00, 8'h35, 8'h04);
    xf(16'h1A10, 12'h010, 8'h80, 8'h0F, 8'h80, 8'h8F, 8'h10);
    $display("test xor register done");
  endtask

  // flags preset to 0x1F must survive the test
  task automatic ts(input logic [15:0] ins, input logic [11:0] ea,
                    input logic [7:0] mv, input logic [15:0] nxt,
                    input int cyc, input logic skip);
    wr(OFF_BANK, 32'h00000002);
    mem_wr(ea, mv);
    wr(OFF_NEXT, {16'h0000, nxt});
    wr(OFF_STATUS, 32'h0000001F);
    run(ins, cyc, skip);
    rdchk(OFF_STATUS, 32'h0000001F, "skip flags");
  endtask

  task automatic t_tstz();
    ts(16'h6734, 12'h234, 8'h00, 16'h0000, 2, 1'b1);
    ts(16'h6634, 12'h034, 8'h00, 16'hEF12, 3, 1'b1);
    ts(16'h6634, 12'h034, 8'h05, 16'hEF12, 1, 1'b0);
    ts(16'h6690, 12'hF90, 8'h00, 16'hC123, 3, 1'b1);
    $display("test skip done");
  endtask

  task automatic tw(input logic [20:0] p, input logic [7:0] lat,
                    input logic [1:0] nn, input int idx,
                    input logic [20:0] ep);
    wr(OFF_TPTR, {11'h0, p});
    wr(OFF_TLAT, {24'h0, lat});
    run({14'h0003, nn}, 2, 1'b0);
    rdchk(8'h20 + 8'(4 * idx), {24'h0, lat}, "holding");
    rdchk(OFF_TPTR, {11'h0, ep}, "pointer");
    rdchk(OFF_TLAT, {24'h0, lat}, "latch kept");
  endtask

  task automatic t_table_write_op();
    tw(21'h00A356, 8'h55, 2'h1, 6, 21'h00A357);
    tw(21'h01389A, 8'h34, 2'h3, 3, 21'h01389B);
    rdchk(8'h28, 32'h000000FF, "holding untouched");
    tw(21'h1FFFFF, 8'hA5, 2'h1, 7, 21'h000000);
    tw(21'h000010, 8'hC3, 2'h2, 0, 21'h00000F);
    tw(21'h000021, 8'h3C, 2'h0, 1, 21'h000021);
    $display("test table write done");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_xorl();
    t_xorf();
    t_tstz();
    t_table_write_op();
    print_verdict();
  end
endmodule
